// ===== hdl/wdtc_pkg.sv
package wdtc_pkg;
   localparam int          CNT_W        = 24;
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 8;
   localparam logic [11:0] CTRL_ADDR    = 12'hFF0;
   localparam logic [11:0] RLD_U_ADDR   = 12'hFF1;
   localparam logic [11:0] RLD_H_ADDR   = 12'hFF2;
   localparam logic [11:0] RLD_L_ADDR   = 12'hFF3;
   localparam logic [7:0]  UNLOCK_KEY1  = 8'h55;
   localparam logic [7:0]  UNLOCK_KEY2  = 8'hAA;
   localparam logic [7:0]  RLD_U_RESET  = 8'hFF;
   localparam logic [7:0]  RLD_H_RESET  = 8'hFF;
   localparam logic [7:0]  RLD_L_RESET  = 8'hFF;
   localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
   localparam logic [23:0] RELOAD_MIN   = 24'h000004;
   localparam int          STAT_WDT_BIT = 5;
   localparam int          STAT_SMR_BIT = 4;
   typedef enum logic [1:0] {RUN_OFF, RUN_ON, RUN_EXPIRED} wdtc_run_type;
   typedef enum logic [1:0] {LCK_LOCKED, LCK_KEY1, LCK_OPEN} wdtc_lock_type;
endpackage

// ===== hdl/wdtc_cnt_if.sv
`timescale 1ns/1ps
interface wdtc_cnt_if;
   logic        load;
   logic [23:0] loadValue;
   logic        dec;
   logic [23:0] count;
   logic        atFloor;
   logic        zero;
   modport ctrl (output load, output loadValue, output dec,
                 input count, input atFloor, input zero);
   modport core (input load, input loadValue, input dec,
                 output count, output atFloor, output zero);
endinterface

// ===== hdl/wdtc_osc_tick.sv
`timescale 1ns/1ps
module wdtc_osc_tick (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic rcOscIn,
   output logic      oscTick
);
   logic syncA_reg;
   logic syncB_reg;
   logic last_reg;

   // two-stage synchroniser, then rising-edge detect on the second stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
         last_reg  <= 1'b0;
      end else begin
         syncA_reg <= rcOscIn;
         syncB_reg <= syncA_reg;
         last_reg  <= syncB_reg;
      end
   end

   assign oscTick = syncB_reg & ~last_reg;
endmodule

// ===== hdl/wdtc_down_counter.sv
`timescale 1ns/1ps
module wdtc_down_counter (
   input wire logic core_clk,
   input wire logic arst_n,
   wdtc_cnt_if.core cnt
);
   logic [23:0] count_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= '0;
      end else if (cnt.load) begin
         count_reg <= cnt.loadValue;
      end else if (cnt.dec && count_reg != '0) begin
         count_reg <= count_reg - 24'h000001;
      end
   end

   assign cnt.count   = count_reg;
   assign cnt.zero    = (count_reg == '0);
   assign cnt.atFloor = (count_reg <= wdtc_pkg::REFRESH_FLOOR);
endmodule

// ===== hdl/wdtc_watchdog.sv
`timescale 1ns/1ps
module wdtc_watchdog (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [11:0] regAddr,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   input  wire logic        refreshInstr,
   input  wire logic        rcOscIn,
   input  wire logic        alwaysOnOption,
   input  wire logic        timeoutResetSelect,
   input  wire logic        stopMode,
   output logic             wdtResetReq,
   output logic             wdtIrqReq,
   output logic             stopRecoveryReq,
   output logic             wdtRunning
);
   wdtc_cnt_if cnt ();

   wdtc_pkg::wdtc_run_type  run_reg;
   wdtc_pkg::wdtc_lock_type lock_reg;
   logic [7:0]  reloadUpper_reg;
   logic [7:0]  reloadHigh_reg;
   logic [7:0]  reloadLow_reg;
   logic [23:0] reloadValue;
   logic        oscTick;
   logic        strapDone_reg;
   logic        startReq;
   logic        refreshOk;
   logic        timeoutEvt;
   logic        statWdt_reg;
   logic        statSmr_reg;
   logic        statRead;
   logic        ctrlWr;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   wdtc_osc_tick u_tick (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .rcOscIn  (rcOscIn),
      .oscTick  (oscTick)
   );

   wdtc_down_counter u_cnt (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .cnt      (cnt)
   );

   assign reloadValue = {reloadUpper_reg, reloadHigh_reg, reloadLow_reg};
   assign ctrlWr      = regWrEn && hit(regAddr, wdtc_pkg::CTRL_ADDR);
   assign statRead    = regRdEn && hit(regAddr, wdtc_pkg::CTRL_ADDR);

   // strap is sampled on the first edge after release, never under reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         strapDone_reg <= 1'b0;
      end else begin
         strapDone_reg <= 1'b1;
      end
   end

   assign startReq  = (!strapDone_reg && alwaysOnOption) || refreshInstr;
   // refresh near terminal count is dropped so a late kick cannot save a hung loop
   assign refreshOk = refreshInstr && !cnt.atFloor;
   assign timeoutEvt = (run_reg == wdtc_pkg::RUN_ON) && cnt.zero;

   always_comb begin
      cnt.load      = 1'b0;
      cnt.loadValue = reloadValue;
      cnt.dec       = (run_reg == wdtc_pkg::RUN_ON) && oscTick;
      unique case (run_reg)
         wdtc_pkg::RUN_OFF:     cnt.load = startReq;
         wdtc_pkg::RUN_ON:      cnt.load = refreshOk;
         wdtc_pkg::RUN_EXPIRED: cnt.load = refreshInstr;
         default:               cnt.load = 1'b0;
      endcase
   end

   // once on it stays on; expiry only parks it until the next kick
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_reg <= wdtc_pkg::RUN_OFF;
      end else begin
         unique case (run_reg)
            wdtc_pkg::RUN_OFF: begin
               if (startReq) begin
                  run_reg <= wdtc_pkg::RUN_ON;
               end
            end
            wdtc_pkg::RUN_ON: begin
               if (timeoutEvt && !refreshOk) begin
                  run_reg <= wdtc_pkg::RUN_EXPIRED;
               end
            end
            wdtc_pkg::RUN_EXPIRED: begin
               if (refreshInstr) begin
                  run_reg <= wdtc_pkg::RUN_ON;
               end
            end
            default: run_reg <= wdtc_pkg::RUN_OFF;
         endcase
      end
   end

   // one pulse per expiry, steered by stop mode and the reset option
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdtResetReq     <= 1'b0;
         wdtIrqReq       <= 1'b0;
         stopRecoveryReq <= 1'b0;
      end else begin
         stopRecoveryReq <= timeoutEvt && stopMode;
         wdtResetReq     <= timeoutEvt && !stopMode && timeoutResetSelect;
         wdtIrqReq       <= timeoutEvt && !stopMode && !timeoutResetSelect;
      end
   end

   assign wdtRunning = (run_reg == wdtc_pkg::RUN_ON);

   // unlock walk: any other control write drops back to locked
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_reg <= wdtc_pkg::LCK_LOCKED;
      end else if (ctrlWr) begin
         if (regWrData == wdtc_pkg::UNLOCK_KEY1) begin
            lock_reg <= wdtc_pkg::LCK_KEY1;
         end else if (regWrData == wdtc_pkg::UNLOCK_KEY2 &&
                      lock_reg == wdtc_pkg::LCK_KEY1) begin
            lock_reg <= wdtc_pkg::LCK_OPEN;
         end else begin
            lock_reg <= wdtc_pkg::LCK_LOCKED;
         end
      end else if (regWrEn && hit(regAddr, wdtc_pkg::RLD_L_ADDR)) begin
         // low byte closes the window, so one unlock covers one update
         lock_reg <= wdtc_pkg::LCK_LOCKED;
      end
   end

   // control writes store nothing: the address only feeds the unlock walk
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reloadUpper_reg <= wdtc_pkg::RLD_U_RESET;
         reloadHigh_reg  <= wdtc_pkg::RLD_H_RESET;
         reloadLow_reg   <= wdtc_pkg::RLD_L_RESET;
      end else if (regWrEn && lock_reg == wdtc_pkg::LCK_OPEN) begin
         if (hit(regAddr, wdtc_pkg::RLD_U_ADDR)) begin
            reloadUpper_reg <= regWrData;
         end
         if (hit(regAddr, wdtc_pkg::RLD_H_ADDR)) begin
            reloadHigh_reg <= regWrData;
         end
         if (hit(regAddr, wdtc_pkg::RLD_L_ADDR)) begin
            reloadLow_reg <= regWrData;
         end
      end
   end

   // sticky status, cleared by reading it; a new event wins over the clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         statWdt_reg <= 1'b0;
         statSmr_reg <= 1'b0;
      end else begin
         statWdt_reg <= (timeoutEvt && !stopMode) || (statWdt_reg && !statRead);
         statSmr_reg <= (timeoutEvt && stopMode) || (statSmr_reg && !statRead);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= 8'h00;
         if (hit(regAddr, wdtc_pkg::CTRL_ADDR)) begin
            regRdData[wdtc_pkg::STAT_WDT_BIT] <= statWdt_reg;
            regRdData[wdtc_pkg::STAT_SMR_BIT] <= statSmr_reg;
         end else if (hit(regAddr, wdtc_pkg::RLD_U_ADDR)) begin
            regRdData <= reloadUpper_reg;
         end else if (hit(regAddr, wdtc_pkg::RLD_H_ADDR)) begin
            regRdData <= reloadHigh_reg;
         end else if (hit(regAddr, wdtc_pkg::RLD_L_ADDR)) begin
            regRdData <= reloadLow_reg;
         end
      end
   end

   sequence s_key1;
      ctrlWr && regWrData == wdtc_pkg::UNLOCK_KEY1;
   endsequence

   sequence s_key2;
      ctrlWr && regWrData == wdtc_pkg::UNLOCK_KEY2 && !regRdEn;
   endsequence

   // an idle cycle between the keys, as software usually leaves one
   sequence s_gap;
      !regWrEn;
   endsequence

   a_unlock_pair: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      s_key1 ##1 s_gap ##1 s_key2 |=> lock_reg == wdtc_pkg::LCK_OPEN)
      else $error("unlock pair did not open reload bytes");

   a_key2_open: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      ctrlWr && regWrData == wdtc_pkg::UNLOCK_KEY2 && lock_reg == wdtc_pkg::LCK_KEY1
      |=> lock_reg == wdtc_pkg::LCK_OPEN)
      else $error("second key did not open reload bytes");

   a_ctrl_no_store: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      ctrlWr |=> $stable(reloadValue))
      else $error("control write changed reload value");

   a_locked_reject: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      regWrEn && lock_reg != wdtc_pkg::LCK_OPEN |=> $stable(reloadValue))
      else $error("reload changed while locked");

   a_refresh_floor: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      run_reg == wdtc_pkg::RUN_ON && cnt.atFloor && refreshInstr |=> cnt.atFloor)
      else $error("refresh accepted at floor");

   a_refresh_load: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      run_reg == wdtc_pkg::RUN_ON && refreshOk |=> cnt.count == $past(reloadValue))
      else $error("refresh did not reload counter");

   a_count_step: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      cnt.dec && !cnt.load && !cnt.zero |=> cnt.count == $past(cnt.count) - 24'h000001)
      else $error("counter did not step by one");

   a_reset_select: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      timeoutEvt && !stopMode |=> wdtResetReq == $past(timeoutResetSelect) &&
                                  wdtIrqReq != $past(timeoutResetSelect))
      else $error("time-out response not per option");

   a_stop_recover: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      timeoutEvt && stopMode |=> stopRecoveryReq && !wdtResetReq && !wdtIrqReq)
      else $error("stop-mode time-out did not start recovery");

   a_one_shot: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (wdtResetReq || wdtIrqReq) && !$past(refreshInstr) |=> !wdtResetReq && !wdtIrqReq)
      else $error("time-out response repeated");

   a_always_on: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !strapDone_reg && alwaysOnOption |=> run_reg != wdtc_pkg::RUN_OFF)
      else $error("always-on option did not start counter");

   a_start_load: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      run_reg == wdtc_pkg::RUN_OFF && startReq |=> wdtRunning && cnt.count == $past(reloadValue))
      else $error("start did not load the counter");

   a_reload_order: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      cnt.load |=> cnt.count == {$past(reloadUpper_reg), $past(reloadHigh_reg), $past(reloadLow_reg)})
      else $error("reload bytes not joined upper, high, low");

   a_tick_only: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !oscTick && !cnt.load |=> $stable(cnt.count))
      else $error("counter moved without an oscillator tick");

   a_count_hold: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      cnt.zero && !cnt.load |=> cnt.zero)
      else $error("counter wrapped below zero");

   a_stays_on: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      run_reg == wdtc_pkg::RUN_ON && !timeoutEvt |=> run_reg == wdtc_pkg::RUN_ON)
      else $error("watchdog switched off while counting");

   a_expire_park: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      timeoutEvt |=> run_reg == wdtc_pkg::RUN_EXPIRED && !wdtRunning)
      else $error("time-out did not park the watchdog");

   a_recover_once: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      stopRecoveryReq |=> !stopRecoveryReq)
      else $error("recovery request repeated");

   a_status_read: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      statRead |=> regRdData[wdtc_pkg::STAT_WDT_BIT] == $past(statWdt_reg) &&
                   regRdData[wdtc_pkg::STAT_SMR_BIT] == $past(statSmr_reg))
      else $error("control read did not return reset status");

   a_status_clear: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      statRead && !timeoutEvt |=> !statWdt_reg && !statSmr_reg)
      else $error("status not cleared by read");
endmodule

// ===== tb/wdtc_watchdog_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errorCnt++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module wdtc_watchdog_tb;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic        regWrEn = 1'b0;
   logic        regRdEn = 1'b0;
   logic [7:0]  regWrData = 8'h00;
   logic [7:0]  regRdData;
   logic        refreshInstr = 1'b0;
   logic        rcOscIn = 1'b0;
   logic        alwaysOnOption = 1'b0;
   logic        timeoutResetSelect = 1'b1;
   logic        stopMode = 1'b0;
   logic        wdtResetReq;
   logic        wdtIrqReq;
   logic        stopRecoveryReq;
   logic        wdtRunning;
   integer      errorCnt = 0;
   integer      testsRun = 0;
   integer      rstN = 0;
   integer      irqN = 0;
   integer      smrN = 0;
   logic [31:0] seed = 32'hA7441658;
   logic [7:0]  rdVal;
   logic [23:0] rv;

   always #5 core_clk = ~core_clk;

   wdtc_watchdog wdtc_watchdog_inst (
      .core_clk           (core_clk),
      .arst_n             (arst_n),
      .regAddr            (regAddr),
      .regWrEn            (regWrEn),
      .regRdEn            (regRdEn),
      .regWrData          (regWrData),
      .regRdData          (regRdData),
      .refreshInstr       (refreshInstr),
      .rcOscIn            (rcOscIn),
      .alwaysOnOption     (alwaysOnOption),
      .timeoutResetSelect (timeoutResetSelect),
      .stopMode           (stopMode),
      .wdtResetReq        (wdtResetReq),
      .wdtIrqReq          (wdtIrqReq),
      .stopRecoveryReq    (stopRecoveryReq),
      .wdtRunning         (wdtRunning)
   );

   // pulse counts stay four-state so an unknown pulse poisons the compare;
   // outputs are unknown before the first edge under reset, so skip reset
   always @(posedge core_clk) begin
      if (arst_n) begin
         rstN += wdtResetReq;
         irqN += wdtIrqReq;
         smrN += stopRecoveryReq;
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [7:0] expStat(input logic stp);
      return stp ? 8'h10 : 8'h20;
   endfunction

   task automatic stopTest;
      if (errorCnt == 0 && testsRun > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [11:0] a);
      regAddr = a;
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      rdVal = regRdData;
      cyc(1);
   endtask

   // synchroniser needs a few core cycles per oscillator level
   task automatic osc(input int n);
      repeat (n) begin
         rcOscIn = 1'b1;
         cyc(4);
         rcOscIn = 1'b0;
         cyc(4);
      end
   endtask

   task automatic refresh;
      refreshInstr = 1'b1;
      cyc(1);
      refreshInstr = 1'b0;
      cyc(1);
   endtask

   task automatic load(input logic [23:0] v);
      wr(wdtc_pkg::CTRL_ADDR, wdtc_pkg::UNLOCK_KEY1);
      wr(wdtc_pkg::CTRL_ADDR, wdtc_pkg::UNLOCK_KEY2);
      wr(wdtc_pkg::RLD_U_ADDR, v[23:16]);
      wr(wdtc_pkg::RLD_H_ADDR, v[15:8]);
      wr(wdtc_pkg::RLD_L_ADDR, v[7:0]);
   endtask

   task automatic expire(input logic sel, input logic stp, input logic [23:0] r);
      integer r0, i0, s0;
      r0 = rstN;
      i0 = irqN;
      s0 = smrN;
      timeoutResetSelect = sel;
      stopMode = stp;
      refresh;
      `CHK("running", 1'b1, wdtRunning)
      osc(int'(r) - 1);
      `CHK("early", r0 + i0 + s0, rstN + irqN + smrN)
      osc(1);
      cyc(4);
      `CHK("reset pulse", r0 + (sel && !stp), rstN)
      `CHK("irq pulse", i0 + (!sel && !stp), irqN)
      `CHK("recovery pulse", s0 + stp, smrN)
      `CHK("stopped", 1'b0, wdtRunning)
      rd(wdtc_pkg::CTRL_ADDR);
      `CHK("status", expStat(stp), rdVal)
      rd(wdtc_pkg::CTRL_ADDR);
      `CHK("status clear", 8'h00, rdVal)
   endtask

   initial begin
      repeat (100000) @(posedge core_clk);
      errorCnt++;
      stopTest;
   end

   initial begin
      cyc(3);
      arst_n = 1'b1;
      cyc(2);
      `CHK("off at reset", 1'b0, wdtRunning)
      for (int k = 1; k < 4; k++) begin
         rd(wdtc_pkg::CTRL_ADDR + 12'(k));
         `CHK("reload reset", wdtc_pkg::RLD_U_RESET, rdVal)
      end
      wr(wdtc_pkg::RLD_L_ADDR, 8'h04);
      rd(wdtc_pkg::RLD_L_ADDR);
      `CHK("locked write", 8'hFF, rdVal)
      // a stray control write between the keys must relock
      wr(wdtc_pkg::CTRL_ADDR, wdtc_pkg::UNLOCK_KEY1);
      wr(wdtc_pkg::CTRL_ADDR, 8'h11);
      wr(wdtc_pkg::CTRL_ADDR, wdtc_pkg::UNLOCK_KEY2);
      wr(wdtc_pkg::RLD_L_ADDR, 8'h04);
      rd(wdtc_pkg::RLD_L_ADDR);
      `CHK("broken unlock", 8'hFF, rdVal)
      load(24'h000004);
      for (int k = 1; k < 4; k++) begin
         rd(wdtc_pkg::CTRL_ADDR + 12'(k));
         `CHK("reload byte", (k == 3) ? 8'h04 : 8'h00, rdVal)
      end
      wr(wdtc_pkg::RLD_U_ADDR, 8'h12);
      rd(wdtc_pkg::RLD_U_ADDR);
      `CHK("relocked", 8'h00, rdVal)
      rd(wdtc_pkg::CTRL_ADDR);
      `CHK("no status", 8'h00, rdVal)
      expire(1'b1, 1'b0, 24'h000004);
      expire(1'b0, 1'b0, 24'h000004);
      expire(1'b0, 1'b1, 24'h000004);
      timeoutResetSelect = 1'b1;
      stopMode = 1'b0;
      refresh;
      osc(2);
      refresh;
      osc(2);
      cyc(4);
      `CHK("floor refresh", 2, rstN)
      refresh;
      osc(1);
      refresh;
      osc(3);
      `CHK("reloaded", 2, rstN)
      osc(1);
      cyc(4);
      `CHK("late expiry", 3, rstN)
      rd(wdtc_pkg::CTRL_ADDR);
      repeat (6) begin
         seed = lfsr(seed);
         rv = 24'h000004 + 24'(seed[2:0]);
         load(rv);
         expire(seed[3], seed[4], rv);
      end
      alwaysOnOption = 1'b1;
      arst_n = 1'b0;
      cyc(3);
      arst_n = 1'b1;
      cyc(2);
      `CHK("always on", 1'b1, wdtRunning)
      rd(wdtc_pkg::RLD_H_ADDR);
      `CHK("reload after reset", wdtc_pkg::RLD_H_RESET, rdVal)
      stopTest;
   end
endmodule
